// >>> core/scpt_defs.svh
`ifndef SCPT_DEFS_SVH
`define SCPT_DEFS_SVH

// ----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SCPT_IDX_TRIM        2'h0
`define SCPT_IDX_PRESCALE    2'h1
`define SCPT_IDX_ASYNC       2'h2

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define SCPT_UNLOCK_BIT      7
`define SCPT_ASYNC_EXTERNAL_CLOCK_SELECT_BIT      6
`define SCPT_TRIM_RANGE_BIT  7
`define SCPT_UNLOCK_PATTERN  8'h80
`define SCPT_DIV_MAX         4'h8
`define SCPT_DIV_RESET_FUSE  4'h3
`define SCPT_DIV_RESET_PLAIN 4'h0

// ----------------------------------------------------------------
// Timing counts, in system clock cycles
// ----------------------------------------------------------------
`define SCPT_UNLOCK_CYCLES   3'h4
`define SCPT_UNLOCK_LAST     3'h1

`endif

// >>> core/scpt_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "scpt_defs.svh"

module scpt_divider (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Division select, taken at period boundaries only
	input  wire logic [3:0] sel_i,
	// Divided clock
	output logic            tick_o,
	output logic            phase_o,
	output logic            bypass_o
);

	scpt_pkg::scpt_div_s q;
	scpt_pkg::scpt_div_s d;

	// ----------------------------------------------------------------
	// Period arithmetic
	// ----------------------------------------------------------------

	// Last count of a period of two to the power sel cycles
	function automatic logic [7:0] last_count(input logic [3:0] sel);
		last_count = 8'((9'h001 << sel) - 9'h001);
	endfunction

	// Cycles spent high in one period
	function automatic logic [7:0] half_count(input logic [3:0] sel);
		half_count = 8'((9'h001 << sel) >> 1);
	endfunction

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------

	// A new select is only taken at the end of a period, so no short pulse
	always_comb begin
		d = q;
		if (q.tick) begin
			d.count = 8'h00;
			d.sel   = sel_i;
		end else begin
			d.count = q.count + 8'h01;
		end
		d.tick   = (d.count == last_count(d.sel));
		d.phase  = (d.count < half_count(d.sel));
		d.bypass = (d.sel == 4'h0);
		if (rst_i) begin
			d        = '0;
			d.tick   = 1'b1;
			d.bypass = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		q <= d;
	end

	assign tick_o   = q.tick;
	assign phase_o  = q.phase;
	assign bypass_o = q.bypass;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	a_period_two: assert property (@(posedge clk_i) disable iff (rst_i)
		(q.tick && q.sel == 4'h1 && sel_i == 4'h1) |=> !q.tick ##1 q.tick)
		else $error("divide by two period wrong");

	a_select_boundary: assert property (@(posedge clk_i) disable iff (rst_i)
		!q.tick |=> $stable(q.sel))
		else $error("division changed inside a period");

endmodule

`default_nettype wire

// >>> core/scpt_pkg.sv
package scpt_pkg;

	// Progress of a division change
	typedef enum logic [2:0] {
		scpt_sw_idle = 3'b001,
		scpt_sw_old  = 3'b010,
		scpt_sw_new  = 3'b100
	} scpt_switch_e;

	// Divider state
	typedef struct packed {
		logic [7:0] count;
		logic [3:0] sel;
		logic       phase;
		logic       tick;
		logic       bypass;
	} scpt_div_s;

	// Control state
	typedef struct packed {
		logic [1:0]   fout_sync;
		logic [1:0]   fdiv_sync;
		logic [15:0]  ftrim_sync;
		logic [3:0]   div;
		logic         unlock;
		logic [2:0]   ucnt;
		logic [7:0]   trim;
		logic         async_external_clock_select;
		scpt_switch_e sw;
		logic         ack;
		logic [7:0]   rdat;
	} scpt_top_s;

endpackage

// >>> core/scpt_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scpt_defs.svh"

module scpt_top #(
	parameter int ADR_W = 4
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	// Fuses and factory calibration
	input  wire logic             clock_output_fuse_i,
	input  wire logic             divide_by_eight_fuse_i,
	input  wire logic [7:0]       factory_trim_i,
	// Clock output pin
	output logic                  system_clock_out_pin_o,
	output logic                  system_clock_out_pin_oe_o,
	output logic                  system_clock_out_bypass_o,
	// Clock domain enables
	output logic                  cpu_clk_en_o,
	output logic                  flash_clk_en_o,
	output logic                  io_clk_en_o,
	output logic                  adc_clk_en_o,
	// Oscillator trim and timer input
	output logic      [7:0]       rc_oscillator_trim_o,
	output logic                  trim_range_select_o,
	output logic                  async_external_clock_select_o,
	// Status
	output logic                  prescale_switching_o
);

	scpt_pkg::scpt_top_s q;
	scpt_pkg::scpt_top_s d;

	logic       tick;
	logic       phase;
	logic       bypass;
	logic       take;
	logic       wr_trim;
	logic       wr_pre;
	logic       wr_async;
	logic [1:0] idx;
	logic [7:0] wdat;
	logic [7:0] rd;

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------

	// One divider feeds every domain, whichever source drives clk_i
	scpt_divider u_div (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.sel_i    (q.div),
		.tick_o   (tick),
		.phase_o  (phase),
		.bypass_o (bypass)
	);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------

	// A request is taken once; ack then stands for one cycle
	assign take     = wb_cyc_i && wb_stb_i && !q.ack;
	assign idx      = wb_adr_i[3:2];
	assign wdat     = wb_dat_i[7:0];
	assign wr_trim  = take && wb_we_i && wb_sel_i[0] && idx == `SCPT_IDX_TRIM;
	assign wr_pre   = take && wb_we_i && wb_sel_i[0] && idx == `SCPT_IDX_PRESCALE;
	assign wr_async = take && wb_we_i && wb_sel_i[0] && idx == `SCPT_IDX_ASYNC;

	// Read mux; unmapped words and unused bits read zero
	always_comb begin
		rd = 8'h00;
		case (idx)
			`SCPT_IDX_TRIM: begin
				rd = q.trim;
			end
			`SCPT_IDX_PRESCALE: begin
				rd[`SCPT_UNLOCK_BIT] = q.unlock;
				rd[3:0] = q.div;
			end
			`SCPT_IDX_ASYNC: begin
				rd[`SCPT_ASYNC_EXTERNAL_CLOCK_SELECT_BIT] = q.async_external_clock_select;
			end
			default: begin
				rd = 8'h00;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	always_comb begin
		d = q;
		// Fuse levels cross in through two flops each
		d.fout_sync  = {q.fout_sync[0], clock_output_fuse_i};
		d.fdiv_sync  = {q.fdiv_sync[0], divide_by_eight_fuse_i};
		d.ftrim_sync = {factory_trim_i, q.ftrim_sync[15:8]};

		// Bus answer
		d.ack = take;
		if (take) begin
			d.rdat = rd;
		end

		// Unlock window counts system cycles, not bus cycles
		if (q.unlock && tick) begin
			if (q.ucnt == `SCPT_UNLOCK_LAST) begin
				d.unlock = 1'b0;
			end else begin
				d.ucnt = q.ucnt - 3'h1;
			end
		end

		// Switch tracking: end of old period, then one new period
		case (q.sw)
			scpt_pkg::scpt_sw_idle: begin
				d.sw = scpt_pkg::scpt_sw_idle;
			end
			scpt_pkg::scpt_sw_old: begin
				if (tick) begin
					d.sw = scpt_pkg::scpt_sw_new;
				end
			end
			scpt_pkg::scpt_sw_new: begin
				if (tick) begin
					d.sw = scpt_pkg::scpt_sw_idle;
				end
			end
			default: begin
				d.sw = scpt_pkg::scpt_sw_idle;
			end
		endcase

		// Prescale writes: unlock pattern, or a locked-in division
		if (wr_pre) begin
			if (wdat == `SCPT_UNLOCK_PATTERN) begin
				if (!q.unlock) begin
					d.unlock = 1'b1;
					d.ucnt   = `SCPT_UNLOCK_CYCLES;
				end
			end else if (!wdat[`SCPT_UNLOCK_BIT] && q.unlock) begin
				d.unlock = 1'b0;
				// Reserved codes are dropped so the divider never overflows
				if (wdat[3:0] <= `SCPT_DIV_MAX) begin
					d.div = wdat[3:0];
					d.sw  = scpt_pkg::scpt_sw_old;
				end
			end
		end

		// Trim retunes the oscillator straight away
		if (wr_trim) begin
			d.trim = wdat;
		end
		if (wr_async) begin
			d.async_external_clock_select = wdat[`SCPT_ASYNC_EXTERNAL_CLOCK_SELECT_BIT];
		end

		// Synchronous reset; hold it three edges so the fuses settle
		if (rst_i) begin
			d.div    = q.fdiv_sync[1] ? `SCPT_DIV_RESET_FUSE : `SCPT_DIV_RESET_PLAIN;
			d.trim   = q.ftrim_sync[7:0];
			d.unlock = 1'b0;
			d.ucnt   = 3'h0;
			d.async_external_clock_select = 1'b0;
			d.sw     = scpt_pkg::scpt_sw_idle;
			d.ack    = 1'b0;
			d.rdat   = 8'h00;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		q <= d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Bus
	assign wb_ack_o = q.ack;
	assign wb_dat_o = {24'h000000, q.rdat};

	// Pin runs during reset too; undivided clock goes through the pad mux
	assign system_clock_out_pin_oe_o = q.fout_sync[1];
	assign system_clock_out_pin_o    = q.fout_sync[1] && phase;
	assign system_clock_out_bypass_o = q.fout_sync[1] && bypass;

	// Every synchronous domain runs on the divided rate
	assign cpu_clk_en_o   = tick;
	assign flash_clk_en_o = tick;
	assign io_clk_en_o    = tick;
	assign adc_clk_en_o   = tick;

	// Range bit and fine bits go to the oscillator unchanged
	assign rc_oscillator_trim_o = q.trim;
	assign trim_range_select_o  = q.trim[`SCPT_TRIM_RANGE_BIT];

	assign async_external_clock_select_o = q.async_external_clock_select;
	assign prescale_switching_o          = (q.sw != scpt_pkg::scpt_sw_idle);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_unlock_write;
		wr_pre && wdat == `SCPT_UNLOCK_PATTERN && !q.unlock;
	endsequence

	sequence s_div_write;
		wr_pre && q.unlock && !wdat[`SCPT_UNLOCK_BIT] && wdat[3:0] <= `SCPT_DIV_MAX;
	endsequence

	a_unlock_opens: assert property (
		s_unlock_write |=> q.unlock && q.ucnt == `SCPT_UNLOCK_CYCLES)
		else $error("unlock did not open a four cycle window");

	a_unlock_expires: assert property (
		(q.unlock && tick && q.ucnt == `SCPT_UNLOCK_LAST && !wr_pre) |=> !q.unlock)
		else $error("unlock outlived its window");

	a_unlock_pattern: assert property (
		(wr_pre && wdat != `SCPT_UNLOCK_PATTERN && !q.unlock) |=> !q.unlock)
		else $error("unlock set by a write with other bits");

	a_unlock_rewrite: assert property (
		(q.unlock && !tick && wr_pre && wdat == `SCPT_UNLOCK_PATTERN)
		|=> q.unlock && $stable(q.ucnt))
		else $error("unlock rewrite changed the window");

	a_div_locked: assert property (
		(!q.unlock && !rst_i) |=> $stable(q.div))
		else $error("division changed without unlock");

	a_div_update: assert property (
		s_div_write |=> q.div == $past(wdat[3:0]) && !q.unlock
		&& q.sw == scpt_pkg::scpt_sw_old)
		else $error("unlocked division write not applied");

	a_switch_steps: assert property (
		(q.sw == scpt_pkg::scpt_sw_old && tick && !wr_pre) |=> q.sw == scpt_pkg::scpt_sw_new)
		else $error("switch sequence out of step");

	a_switch_ends: assert property (
		(q.sw == scpt_pkg::scpt_sw_new && tick && !wr_pre) |=> q.sw == scpt_pkg::scpt_sw_idle)
		else $error("switch did not end after one new period");

	a_reset_load: assert property (disable iff (1'b0)
		($past(rst_i) && !rst_i) |-> q.div == ($past(q.fdiv_sync[1]) ?
		`SCPT_DIV_RESET_FUSE : `SCPT_DIV_RESET_PLAIN) && q.trim == $past(q.ftrim_sync[7:0]))
		else $error("reset load of division or trim wrong");

	a_pad_bits_zero: assert property (
		(take && idx == `SCPT_IDX_PRESCALE) |=> wb_ack_o && wb_dat_o[6:4] == 3'h0)
		else $error("unused prescale bits not zero");

	a_ext_select: assert property (
		wr_async |=> async_external_clock_select_o == $past(wdat[`SCPT_ASYNC_EXTERNAL_CLOCK_SELECT_BIT]))
		else $error("external clock select not applied");

	// A divided period ends low and the next one starts high
	a_pin_follow: assert property (
		(system_clock_out_pin_oe_o && !bypass && tick) |-> !system_clock_out_pin_o
		##1 (system_clock_out_pin_o || system_clock_out_bypass_o))
		else $error("pin not carrying divided clock");

endmodule

`default_nettype wire

// >>> verification/scpt_clock_sink.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Board load on the clock output pin
// ------------------------------------------------------------
module scpt_clock_sink (
	// Clock and pin
	input  wire logic       clk_i,
	input  wire logic       pin_i,
	input  wire logic       oe_i,
	input  wire logic       bypass_i,
	// Last period seen, in source cycles
	output logic      [9:0] period_o
);
	logic       level;
	logic       prev = 1'b0;
	logic [9:0] cnt  = 10'h0;

	// Pad has a pull-down, so an undriven pin reads low
	assign level = oe_i & pin_i;

	// Time rising edges; bypass passes the source clock itself
	always @(posedge clk_i) begin
		prev <= level;
		cnt  <= cnt + 10'h1;
		if (oe_i && bypass_i) begin
			period_o <= 10'h1;
		end else if (level && !prev) begin
			period_o <= cnt + 10'h1;
			cnt      <= 10'h0;
		end
	end
endmodule

`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("ERROR %s exp %0h got %0h", nm, e, a); end end

module tb;
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic        fout = 1'b1, fdiv = 1'b1;
	logic [3:0]  adr = 4'h0, sel = 4'h1;
	logic [31:0] dw = 32'h0, rd, dr;
	logic [7:0]  ftrim = 8'h5a, trim;
	logic        ack, pin, oe, byp, cpu_en, fl_en, io_en, adc_en, rsel, ext, sw;
	logic [9:0]  period;
	int          bad_count = 0, num_checks = 0, cur = 3;

	// 200 MHz source clock
	always #2.5 clk = ~clk;

	scpt_top scpt_top_i (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
		.wb_ack_o(ack), .clock_output_fuse_i(fout), .divide_by_eight_fuse_i(fdiv),
		.factory_trim_i(ftrim), .system_clock_out_pin_o(pin),
		.system_clock_out_pin_oe_o(oe), .system_clock_out_bypass_o(byp),
		.cpu_clk_en_o(cpu_en), .flash_clk_en_o(fl_en), .io_clk_en_o(io_en),
		.adc_clk_en_o(adc_en), .rc_oscillator_trim_o(trim), .trim_range_select_o(rsel),
		.async_external_clock_select_o(ext), .prescale_switching_o(sw));

	scpt_clock_sink scpt_clock_sink_i (.clk_i(clk), .pin_i(pin), .oe_i(oe),
		.bypass_i(byp), .period_o(period));

	// ------------------------------------------------------------
	// Bus and helpers
	// ------------------------------------------------------------
	// Classic cycle; request held until ack is sampled, then released
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dw  <= {24'h0, d};
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Interrupts are assumed off: the two writes go back to back
	task automatic set_div(input logic [7:0] v);
		int n;
		int e;
		wb(1'b1, 4'h4, 8'h80);
		wb(1'b1, 4'h4, v);
		if (v < 9) begin
			// Count the domain enables seen while the switch is under way
			e = 0;
			for (n = 0; n < 2000 && sw !== 1'b0; n++) begin
				if (cpu_en === 1'b1) begin
					e++;
				end
				@(posedge clk);
			end
			`CHK("switch span", 1'b1, n <= (1 << cur) + 2 * (1 << v) + 4)
			`CHK("switch edges", 2, e)
			cur = v;
		end
	endtask

	// Pin period and the four domain enables must follow the division
	task automatic check_rate(input int k);
		int n;
		repeat ((2 << k) + 4) @(posedge clk);
		`CHK("pin period", 10'(1 << k), period)
		for (n = 0; n < 600 && cpu_en !== 1'b1; n++) @(posedge clk);
		n = 0;
		do begin
			@(posedge clk);
			n++;
			`CHK("enables", {4{cpu_en}}, {fl_en, io_en, adc_en, cpu_en})
		end while (cpu_en !== 1'b1 && n < 600);
		`CHK("enable period", 1 << k, n)
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset(input logic fo, input logic fd);
		@(posedge clk);
		fout <= fo;
		fdiv <= fd;
		rst  <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK("oe in reset", fo, oe)
		rst <= 1'b0;
		cur = fd ? 3 : 0;
		wb(1'b0, 4'h0, 8'h0);
		`CHK("trim reset", {24'h0, ftrim}, rd)
		wb(1'b0, 4'h4, 8'h0);
		`CHK("prescale reset", fd ? 32'h3 : 32'h0, rd)
		wb(1'b0, 4'h8, 8'h0);
		`CHK("async reset", 32'h0, rd)
		`CHK("pin gated", 1'b0, pin & ~fo)
		`CHK("oe run", fo, oe)
	endtask

	task automatic t_trim();
		logic [7:0] tv [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
		foreach (tv[i]) begin
			// No flash or EEPROM write runs while the trim goes to the top
			wb(1'b1, 4'h0, tv[i]);
			wb(1'b0, 4'h0, 8'h0);
			`CHK("trim read", {24'h0, tv[i]}, rd)
			`CHK("trim out", tv[i], trim)
			`CHK("range", tv[i][7], rsel)
		end
		// A write with its byte lane off must leave the trim alone
		sel <= 4'h0;
		wb(1'b1, 4'h0, 8'h11);
		sel <= 4'h1;
		wb(1'b0, 4'h0, 8'h0);
		`CHK("lane off", 32'hff, rd)
	endtask

	// Async select plus an unmapped word that must read zero
	task automatic t_async();
		// Timer input is only switched, never clocked, so no ratio or source limit
		wb(1'b1, 4'h8, 8'h40);
		`CHK("ext on", 1'b1, ext)
		wb(1'b1, 4'h8, 8'h00);
		`CHK("ext off", 1'b0, ext)
		wb(1'b1, 4'hc, 8'hff);
		wb(1'b0, 4'hc, 8'h0);
		`CHK("unmapped", 32'h0, rd)
		// Left on so that the later reset has something to clear
		wb(1'b1, 4'h8, 8'h40);
	endtask

	task automatic t_sweep();
		for (int k = 0; k < 9; k++) begin
			set_div(8'(k));
			wb(1'b0, 4'h4, 8'h0);
			`CHK("division", 32'(k), rd)
			check_rate(k);
		end
	endtask

	task automatic t_guard();
		set_div(8'h09);
		wb(1'b0, 4'h4, 8'h0);
		`CHK("reserved", 32'h8, rd)
		wb(1'b1, 4'h4, 8'h02);
		wb(1'b0, 4'h4, 8'h0);
		`CHK("locked", 32'h8, rd)
		wb(1'b1, 4'h4, 8'h80);
		set_div(8'h02);
		wb(1'b0, 4'h4, 8'h0);
		`CHK("rewrite", 32'h2, rd)
		check_rate(2);
		wb(1'b1, 4'h4, 8'h81);
		wb(1'b1, 4'h4, 8'h03);
		wb(1'b0, 4'h4, 8'h0);
		`CHK("mixed unlock", 32'h2, rd)
		wb(1'b1, 4'h4, 8'h80);
		repeat (24) @(posedge clk);
		wb(1'b1, 4'h4, 8'h03);
		wb(1'b0, 4'h4, 8'h0);
		`CHK("expired", 32'h2, rd)
		wb(1'b1, 4'h4, 8'h80);
		wb(1'b1, 4'h4, 8'h01);
		wb(1'b1, 4'h4, 8'h00);
		wb(1'b1, 4'h4, 8'h70);
		wb(1'b0, 4'h4, 8'h0);
		`CHK("used once", 32'h1, rd)
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		t_reset(1'b1, 1'b1);
		t_trim();
		t_async();
		t_sweep();
		t_guard();
		t_reset(1'b0, 1'b0);
		give_verdict();
	end

	// Whole run is a few thousand cycles; this leaves ample margin
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		give_verdict();
	end
endmodule

`default_nettype wire
